// >>> design/lamp_bank_cfg.svh
`ifndef LAMP_BANK_CFG_SVH
`define LAMP_BANK_CFG_SVH

// power-on values
`define BRIGHT_RESET      5'h17
`define SHMD_RESET        3'h1
`define STATUS_RESET      2'h3
`define POINTER_RESET     8'h80

// shutdown-mode field positions
`define SHMD_FORCE_BIT    2
`define SHMD_HIGH_BIT     1
`define SHMD_LOW_BIT      0

// status field positions
`define STATUS_LAMP_BIT   1
`define STATUS_NOOC_BIT   0

// command byte decode: top two bits, then low bits
`define CMD_TOP_SHORT     2'h0
`define CMD_TOP_LEFT      2'h2
`define CMD_TOP_ID        2'h3
`define CMD_LOW_BRIGHT    2'h1
`define CMD_LOW_SHMD      2'h2
`define CMD_LOW_PART      2'h3
`define CMD_LOW_REV       2'h0

// fixed fill bits of the packed views
`define SHMD_VIEW_FILL    3'h7
`define LEFT_VIEW_FILL    1'h1

// link frame lengths in bits
`define FRAME_SEND_BITS   5'h08
`define FRAME_WRITE_BITS  5'h10
`define FRAME_MAX_BITS    5'h1F

// lamp-out timeout
`define LAMP_OUT_TIMEOUT_S 2
`define CLOCK_HZ           10000000

`endif

// >>> design/lamp_bank_pkg.sv
package lamp_bank_pkg;

  // register selected by a command byte
  typedef enum logic [2:0] {
    SEL_BRIGHT = 3'b000,
    SEL_SHMD   = 3'b001,
    SEL_PART   = 3'b010,
    SEL_REV    = 3'b011,
    SEL_LEFT   = 3'b100,
    SEL_MAKER  = 3'b101
  } reg_sel_t;

  // fault status flags
  typedef struct packed {
    logic lamp_present_flag;
    logic no_overcurrent_flag;
  } status_t;

  // shutdown-mode field
  typedef struct packed {
    logic force_off_bit;
    logic pin_high_off_bit;
    logic pin_low_off_bit;
  } shutdown_mode_t;

endpackage : lamp_bank_pkg

// >>> design/lamp_control_register_bank.sv
// Overview of operation
// - five-bit brightness code drives dimming output
// - brightness code resets to 0b10111
// - dimming method comes only from input
// - three-bit shutdown mode field resets 0b001
// - force-off bit shuts lamp, sets present
// - pin high: middle bit shuts lamp
// - pin low: low bit shuts lamp
// - operate only when both selected bits zero
// - lamp-out two seconds clears present flag
// - cleared present flag latches, holds lamp off
// - present flag set by shutdown or toggle
// - overcurrent flag reports previous pwm period
// - status: present bit1, no-overcurrent bit0
// - status writes ignored
// - identification registers fixed, writes ignored
// - writes take effect at frame end
// - incomplete frames are discarded
`timescale 1ns/1ps
`include "lamp_bank_cfg.svh"

module lamp_control_register_bank #(
  parameter int         LAMP_OUT_CYCLES = `LAMP_OUT_TIMEOUT_S * `CLOCK_HZ,
  parameter logic [7:0] MAKER_CODE      = 8'h5A,  // arbitrary value
  parameter logic [7:0] PART_CODE       = 8'h3C,  // arbitrary value
  parameter logic [7:0] REVISION_CODE   = 8'h01   // arbitrary value
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_link_clock,
  input  wire logic       i_link_frame,
  input  wire logic       i_link_data,
  output logic            o_link_read_data,
  input  wire logic       i_shutdown_suspend_pin,
  input  wire logic       i_lamp_current_average,
  input  wire logic       i_overcurrent,
  input  wire logic       i_pwm_period_start,
  input  wire logic [1:0] i_dimming_method_select,
  output logic [4:0]      o_brightness_code,
  output logic [1:0]      o_dimming_method,
  output logic            o_lamp_enable,
  output logic [1:0]      o_fault_status
);

  // ---------------- link domain ----------------
  logic        armed_q;
  logic [4:0]  bit_count_q;
  logic [15:0] link_shift_q;
  logic [6:0]  tx_shift_q;
  logic        tx_bit_q;
  logic [7:0]  read_snap_q;

  // marks the first edge of a frame; the frame's own end clears it
  always_ff @(posedge i_link_clock or negedge i_link_frame) begin
    if (!i_link_frame) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  // bit counter and receive shift; left standing after the frame
  always_ff @(posedge i_link_clock) begin
    if (!armed_q) begin
      bit_count_q <= 5'h01;
    end else if (bit_count_q != `FRAME_MAX_BITS) begin
      bit_count_q <= bit_count_q + 5'h01;
    end
    link_shift_q <= {link_shift_q[14:0], i_link_data};
  end

  // read data out, msb first, snapshot loaded at the first edge
  // frame low clears the bit, so the line idles low between frames
  always_ff @(posedge i_link_clock or negedge i_link_frame) begin
    if (!i_link_frame) begin
      tx_bit_q   <= 1'b0;
      tx_shift_q <= 7'h00;
    end else if (!armed_q) begin
      tx_bit_q   <= read_snap_q[7];
      tx_shift_q <= read_snap_q[6:0];
    end else begin
      tx_bit_q   <= tx_shift_q[6];
      tx_shift_q <= {tx_shift_q[5:0], 1'b0};
    end
  end

  // read data pin straight from its flop
  assign o_link_read_data = tx_bit_q;

  // ---------------- system domain ----------------
  logic [1:0] frame_sync_q;
  logic       frame_prev_q;
  logic [1:0] pin_sync_q;
  logic       pin_prev_q;
  logic [1:0] current_sync_q;
  logic [1:0] oc_sync_q;

  // frame marker sync and its delayed copy for the end edge
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      frame_sync_q <= 2'h0;
      frame_prev_q <= 1'b0;
    end else begin
      frame_sync_q <= {frame_sync_q[0], i_link_frame};
      frame_prev_q <= frame_sync_q[1];
    end
  end

  // lamp current comparator sync
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      current_sync_q <= 2'h0;
    end else begin
      current_sync_q <= {current_sync_q[0], i_lamp_current_average};
    end
  end

  // overcurrent comparator sync
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      oc_sync_q <= 2'h0;
    end else begin
      oc_sync_q <= {oc_sync_q[0], i_overcurrent};
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pin_sync_q <= 2'h0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], i_shutdown_suspend_pin};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  logic pin_level;
  logic pin_toggled;
  logic frame_done;
  assign pin_level   = pin_sync_q[1];
  assign pin_toggled = pin_sync_q[1] ^ pin_prev_q;
  assign frame_done  = frame_prev_q & ~frame_sync_q[1];

  // command decode shared by read and write paths
  function automatic lamp_bank_pkg::reg_sel_t decode(input logic [7:0] cmd);
    lamp_bank_pkg::reg_sel_t sel;
    sel = lamp_bank_pkg::SEL_BRIGHT;
    if (cmd[7:6] == `CMD_TOP_LEFT) begin
      sel = lamp_bank_pkg::SEL_LEFT;
    end else if (cmd[7:6] == `CMD_TOP_ID) begin
      sel = cmd[0] ? lamp_bank_pkg::SEL_PART : lamp_bank_pkg::SEL_MAKER;
    end else if (cmd[7] == 1'b0) begin
      unique case (cmd[1:0])
        `CMD_LOW_BRIGHT: sel = lamp_bank_pkg::SEL_BRIGHT;
        `CMD_LOW_SHMD:   sel = lamp_bank_pkg::SEL_SHMD;
        `CMD_LOW_PART:   sel = lamp_bank_pkg::SEL_PART;
        `CMD_LOW_REV:    sel = lamp_bank_pkg::SEL_REV;
      endcase
    end
    return sel;
  endfunction : decode

  logic [7:0]                    pointer_q;
  logic [4:0]                    bright_q;
  lamp_bank_pkg::shutdown_mode_t shmd_q;
  lamp_bank_pkg::status_t        status_q;
  logic                          lamp_present_q;
  logic                          no_oc_q;
  logic                          write_valid;
  logic [7:0]                    write_cmd;
  logic [7:0]                    write_data;
  lamp_bank_pkg::reg_sel_t       write_sel;

  // shift and count are quiet here: the link clock stops after a frame
  // discard partial frames
  assign write_valid = frame_done && (bit_count_q == `FRAME_WRITE_BITS);
  assign write_cmd   = link_shift_q[15:8];
  assign write_data  = link_shift_q[7:0];
  assign write_sel   = decode(write_cmd);

  // a one-byte frame only moves the pointer
  // commit at frame end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pointer_q <= `POINTER_RESET;
    end else if (write_valid) begin
      pointer_q <= write_cmd;
    end else if (frame_done && (bit_count_q == `FRAME_SEND_BITS)) begin
      pointer_q <= link_shift_q[7:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      bright_q <= `BRIGHT_RESET;
    end else if (write_valid && write_sel == lamp_bank_pkg::SEL_BRIGHT) begin
      bright_q <= write_data[4:0];
    end else if (write_valid && write_sel == lamp_bank_pkg::SEL_LEFT) begin
      bright_q <= write_data[7:3];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      shmd_q <= `SHMD_RESET;
    end else if (write_valid && write_sel == lamp_bank_pkg::SEL_SHMD) begin
      shmd_q <= write_data[2:0];
    end
  end

  // shutdown decision
  // recomputed every clock from the synchronised pin level
  logic shutdown;
  logic pin_bit;
  assign pin_bit  = pin_level ? shmd_q[`SHMD_HIGH_BIT] : shmd_q[`SHMD_LOW_BIT];
  assign shutdown = shmd_q[`SHMD_FORCE_BIT] | pin_bit;

  // lamp-out timer, runs while the lamp is driven without current
  // 25 bits cover the full two-second count at the system clock
  localparam int TW = 25;
  logic [TW-1:0] lamp_out_count_q;
  logic          lamp_out_expired;
  assign lamp_out_expired = (lamp_out_count_q == TW'(LAMP_OUT_CYCLES - 1));

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lamp_out_count_q <= '0;
    end else if (!o_lamp_enable || current_sync_q[1] || lamp_out_expired) begin
      lamp_out_count_q <= '0;
    end else begin
      lamp_out_count_q <= lamp_out_count_q + TW'(1);
    end
  end

  // latched clear otherwise; set wins over clear
  // a toggle is seen only after the pin synchroniser
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lamp_present_q <= 1'(`STATUS_RESET >> `STATUS_LAMP_BIT);
    end else if (shutdown || pin_toggled) begin
      lamp_present_q <= 1'b1;
    end else if (o_lamp_enable && lamp_out_expired) begin
      lamp_present_q <= 1'b0;
    end
  end

  // overcurrent seen within the running pwm period
  logic oc_seen_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      oc_seen_q <= 1'b0;
    end else if (i_pwm_period_start) begin
      oc_seen_q <= 1'b0;
    end else if (oc_sync_q[1]) begin
      oc_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      no_oc_q <= 1'(`STATUS_RESET >> `STATUS_NOOC_BIT);
    end else if (i_pwm_period_start) begin
      no_oc_q <= ~(oc_seen_q | oc_sync_q[1]);
    end
  end

  // status view assembled from the two flag flops
  assign status_q = {lamp_present_q, no_oc_q};

  // read value of the register the pointer selects
  logic [7:0] read_value;
  always_comb begin
    read_value = 8'h00;
    unique case (decode(pointer_q))
      lamp_bank_pkg::SEL_BRIGHT: read_value = {3'h0, bright_q};
      lamp_bank_pkg::SEL_SHMD:   read_value = {status_q, `SHMD_VIEW_FILL, shmd_q};
      lamp_bank_pkg::SEL_LEFT:   read_value = {bright_q, `LEFT_VIEW_FILL, status_q};
      lamp_bank_pkg::SEL_PART:   read_value = PART_CODE;
      lamp_bank_pkg::SEL_REV:    read_value = REVISION_CODE;
      lamp_bank_pkg::SEL_MAKER:  read_value = MAKER_CODE;
    endcase
  end

  // snapshot for the link, frozen while a frame runs
  // hosts leave four clocks before the first edge so it has settled
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      read_snap_q <= {`BRIGHT_RESET, `LEFT_VIEW_FILL, `STATUS_RESET};
    end else if (!frame_sync_q[1]) begin
      read_snap_q <= read_value;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_brightness_code <= `BRIGHT_RESET;
    end else begin
      o_brightness_code <= bright_q;
    end
  end

  // status not writable
  // status flags to the pins
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_fault_status <= `STATUS_RESET;
    end else begin
      o_fault_status <= status_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_dimming_method <= 2'h0;
    end else begin
      o_dimming_method <= i_dimming_method_select;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_lamp_enable <= 1'b0;
    end else begin
      o_lamp_enable <= ~shutdown & status_q.lamp_present_flag;
    end
  end

endmodule : lamp_control_register_bank

// >>> dv/lamp_bank_asserts.sv
`timescale 1ns/1ps
module lamp_bank_asserts #(
  parameter int LAMP_OUT_CYCLES = 50
) (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_link_frame,
  input wire logic       o_link_read_data,
  input wire logic       i_shutdown_suspend_pin,
  input wire logic       i_pwm_period_start,
  input wire logic [1:0] i_dimming_method_select,
  input wire logic [4:0] o_brightness_code,
  input wire logic [1:0] o_dimming_method,
  input wire logic       o_lamp_enable,
  input wire logic [1:0] o_fault_status
);
  int on_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // consecutive cycles with the lamp running
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !o_lamp_enable) on_q <= 0;
    else on_q <= on_q + 1;
  end
  reset_vals_a: assert property (
    $rose(i_rst_n) |-> o_brightness_code == 5'h17 && o_fault_status == 2'h3 && !o_lamp_enable)
    else $error("wrong values after reset");
  method_copy_a: assert property (
    $past(i_rst_n) |-> o_dimming_method == $past(i_dimming_method_select))
    else $error("dimming method not taken from input");
  toggle_sets_a: assert property (
    $changed(i_shutdown_suspend_pin) |-> ##[1:6] o_fault_status[1])
    else $error("pin toggle did not set present flag");
  held_off_a: assert property (
    !o_fault_status[1] |-> !o_lamp_enable)
    else $error("lamp runs with present flag clear");
  period_flag_a: assert property (
    !$stable(o_fault_status[0]) |-> $past(i_pwm_period_start, 2))
    else $error("overcurrent flag moved inside a period");
  lamp_out_time_a: assert property (
    $fell(o_fault_status[1]) |-> on_q >= LAMP_OUT_CYCLES - 3)
    else $error("present flag cleared too early");
  read_idle_a: assert property (
    !i_link_frame && !$past(i_link_frame) |-> !o_link_read_data)
    else $error("read data not low outside frame");
  bright_hold_a: assert property (
    i_link_frame && $past(i_link_frame, 3) |-> $stable(o_brightness_code))
    else $error("brightness changed inside a frame");
endmodule : lamp_bank_asserts

bind lamp_control_register_bank lamp_bank_asserts #(.LAMP_OUT_CYCLES(LAMP_OUT_CYCLES)) chk (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_link_frame(i_link_frame),
  .o_link_read_data(o_link_read_data), .i_shutdown_suspend_pin(i_shutdown_suspend_pin),
  .i_pwm_period_start(i_pwm_period_start), .i_dimming_method_select(i_dimming_method_select),
  .o_brightness_code(o_brightness_code), .o_dimming_method(o_dimming_method),
  .o_lamp_enable(o_lamp_enable), .o_fault_status(o_fault_status));

// >>> dv/link_host.sv
`timescale 1ns/1ps
module link_host (
  output logic       o_link_clock,
  output logic       o_link_frame,
  output logic       o_link_data,
  input  wire logic  i_read_data,
  output logic [7:0] o_byte,
  output logic       o_done
);
  initial begin
    o_link_clock = 1'b0;
    o_link_frame = 1'b0;
    o_link_data = 1'b0;
    o_byte = 8'h00;
    o_done = 1'b0;
  end
  // one frame of n bits, msb first; the clock runs only inside it
  task automatic xfer(input logic [15:0] bits, input int n);
    o_link_frame = 1'b1;
    #403;
    for (int i = 0; i < n; i++) begin
      o_link_data = bits[15-i];
      #40 o_link_clock = 1'b1;
      #40 o_link_clock = 1'b0;
      if (i < 8) o_byte[7-i] = i_read_data;
    end
    #40 o_link_frame = 1'b0;
    // a released data line does not keep its last level
    o_link_data = ~o_link_data;
    #600 o_done = 1'b1;
    #100 o_done = 1'b0;
  endtask : xfer
endmodule : link_host

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk, rst_n, lclk, frame, ldata, rdata, pin, cur, oc, pwm, done, want, lamp_en;
  logic [1:0]  meth, method, status;
  logic [4:0]  bright;
  logic [7:0]  rbyte;
  logic [31:0] seed, v;
  logic [7:0]  q[$];
  logic [7:0]  rc[6] = '{8'h80, 8'h02, 8'hFE, 8'h03, 8'h04, 8'hFF};
  logic [7:0]  rv[6] = '{8'hBF, 8'hF9, 8'h5A, 8'h3C, 8'h01, 8'h3C};
  int          err_total, comparisons;

  lamp_control_register_bank #(.LAMP_OUT_CYCLES(50)) dut (
    .i_clock(clk), .i_rst_n(rst_n), .i_link_clock(lclk), .i_link_frame(frame),
    .i_link_data(ldata), .o_link_read_data(rdata), .i_shutdown_suspend_pin(pin),
    .i_lamp_current_average(cur), .i_overcurrent(oc), .i_pwm_period_start(pwm),
    .i_dimming_method_select(meth), .o_brightness_code(bright),
    .o_dimming_method(method), .o_lamp_enable(lamp_en), .o_fault_status(status));
  link_host host (.o_link_clock(lclk), .o_link_frame(frame), .o_link_data(ldata),
    .i_read_data(rdata), .o_byte(rbyte), .o_done(done));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick
  // first frame points at the register, second one reads it
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    host.xfer({c, 8'h00}, 8);
    q.push_back(e);
    want = 1'b1;
    host.xfer({c, 8'h00}, 8);
    want = 1'b0;
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host.xfer({c, d}, 16);
    tick(1);
  endtask : wr
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // compare each checked read with the oldest expectation
  always @(posedge done)
    if (want) check(rbyte, q.pop_front());
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // cut a hang short
  initial begin
    #3000000;
    err_total++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    pin = 1'b0;
    cur = 1'b1;
    oc = 1'b0;
    pwm = 1'b0;
    meth = 2'h0;
    want = 1'b0;
    seed = 32'hF0BC9D8E;
    tick(10);
    rst_n = 1'b1;
    tick(3);
    check(8'(bright), 8'h17);
    check(8'(status), 8'h03);
    wr(8'h03, 8'h00);
    wr(8'hFE, 8'h00);
    wr(8'h04, 8'hFF);
    // views, and fixed codes after writes to the fixed codes
    for (int i = 0; i < 6; i++) rd(rc[i], rv[i]);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = seed;
      if (i < 2) v[4:0] = {5{i[0]}};
      meth = v[9:8];
      wr(8'h01, v[7:0]);
      check(8'(bright), 8'(v[4:0]));
      check(8'(method), 8'(v[9:8]));
    end
    host.xfer({8'h01, ~v[7:0]}, 12);
    tick(2);
    check(8'(bright), 8'(v[4:0]));
    wr(8'h80, 8'hA8);
    check(8'(bright), 8'h15);
    // lamp decision over pin level and mode
    for (int i = 0; i < 16; i++) begin
      pin = i[3];
      wr(8'h02, 8'(i[2:0]));
      tick(4);
      check(8'(lamp_en), 8'(!(i[2] || (i[3] ? i[1] : i[0]))));
      check(8'(status), 8'h03);
    end
    // lamp-out latch and both ways back
    pin = 1'b0;
    wr(8'h02, 8'h00);
    cur = 1'b0;
    tick(60);
    check(8'(status), 8'h01);
    check(8'(lamp_en), 8'h00);
    cur = 1'b1;
    tick(10);
    check(8'(status), 8'h01);
    pin = 1'b1;
    tick(6);
    check(8'(status), 8'h03);
    check(8'(lamp_en), 8'h01);
    cur = 1'b0;
    tick(60);
    check(8'(status), 8'h01);
    wr(8'h02, 8'h04);
    check(8'(status), 8'h03);
    oc = 1'b1;
    tick(3);
    oc = 1'b0;
    tick(3);
    pwm = 1'b1;
    tick(1);
    pwm = 1'b0;
    tick(20);
    check(8'(status), 8'h02);
    pwm = 1'b1;
    tick(1);
    pwm = 1'b0;
    tick(2);
    check(8'(status), 8'h03);
    test_done();
  end
endmodule : tb
